// ===== design/buck_current_trim_registers.sv
// Read-only trimming word bank for the peak-current sensing of two buck channels.
`timescale 1ns/1ps
module buck_current_trim_registers (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic bank_select,
   input wire logic rd_en,
   input wire logic [4:0] rd_addr,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire buck_trim_pkg::trim_bank_type trim_ch1,
   input wire buck_trim_pkg::trim_bank_type trim_ch2,
   input wire buck_trim_pkg::coeff_set_type coeff_in,
   output logic [9:0] rd_data_r,
   output logic rd_valid_r,
   output logic addr_hit_r,
   output logic wr_refused_r
);

   buck_trim_pkg::trim_bank_type bank_r [2];
   buck_trim_pkg::coeff_set_type coeff_r;
   buck_trim_pkg::trim_bank_type bank_view;
   logic [9:0] rd_data_nxt;
   logic hit_nxt;

   // Odd parity in bit 8, bit 9 forced low.
   function automatic logic [9:0] pack_word(input logic [7:0] payload);
      pack_word = {1'b0, ~^payload, payload};
   endfunction

   function automatic logic trim_addr(input logic [4:0] a);
      trim_addr = (a >= buck_trim_pkg::OFS_RANGE_FIVE_HOT_TRIM) &&
                  (a <= buck_trim_pkg::OFS_UNUSED_TEMP_COEFF);
   endfunction

   // Trim is captured while reset is held, so the words are valid from the
   // first edge after release; nothing writes them afterwards.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bank_r[0] <= trim_ch1;
         bank_r[1] <= trim_ch2;
         coeff_r <= coeff_in;
      end
   end

   // The selected bank is looked up at read time, so no stale copy exists.
   always_comb begin
      bank_view = bank_select ? bank_r[1] : bank_r[0];
   end

   always_comb begin
      rd_data_nxt = buck_trim_pkg::READ_DATA_RESET;
      hit_nxt = trim_addr(rd_addr);
      unique case (rd_addr)
         buck_trim_pkg::OFS_RANGE_FIVE_HOT_TRIM: begin
            rd_data_nxt = pack_word({1'b0, bank_view.range_five_hot_constant});
         end
         buck_trim_pkg::OFS_RANGE_DELTA_TWO_ONE: begin
            rd_data_nxt = pack_word({bank_view.range_delta_two,
                                     bank_view.range_delta_one});
         end
         buck_trim_pkg::OFS_RANGE_DELTA_FOUR_THREE: begin
            rd_data_nxt = pack_word({bank_view.range_delta_four,
                                     bank_view.range_delta_three});
         end
         buck_trim_pkg::OFS_TEMP_COEFF_CHANNEL_ONE: begin
            rd_data_nxt = pack_word({coeff_r.ch1_high_range_coeff,
                                     coeff_r.ch1_low_range_coeff});
         end
         buck_trim_pkg::OFS_TEMP_COEFF_CHANNEL_TWO: begin
            rd_data_nxt = pack_word({coeff_r.ch2_high_range_coeff,
                                     coeff_r.ch2_low_range_coeff});
         end
         buck_trim_pkg::OFS_UNUSED_TEMP_COEFF: begin
            // Parity is deliberately not applied: this word reads all zero.
            rd_data_nxt = buck_trim_pkg::UNUSED_TEMP_COEFF_RESET;
         end
         default: begin
            rd_data_nxt = buck_trim_pkg::READ_DATA_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_data_r <= buck_trim_pkg::READ_DATA_RESET;
         rd_valid_r <= 1'b0;
         addr_hit_r <= 1'b0;
      end else if (clk_en) begin
         rd_valid_r <= rd_en;
         if (rd_en) begin
            rd_data_r <= rd_data_nxt;
            addr_hit_r <= hit_nxt;
         end
      end
   end

   // A write to a trimming word is only reported; storage has no write path.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_refused_r <= 1'b0;
      end else if (clk_en) begin
         wr_refused_r <= wr_en && trim_addr(wr_addr);
      end
   end

   sequence seq_rd(logic [4:0] a);
      clk_en && rd_en && rd_addr == a;
   endsequence

   sequence seq_bank_flip;
      clk_en && rd_en && $changed(bank_select);
   endsequence

   AST_BANK_VIEW: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_RANGE_DELTA_TWO_ONE) |=>
      rd_data_r[7:0] == (($past(bank_select)) ?
         {bank_r[1].range_delta_two, bank_r[1].range_delta_one} :
         {bank_r[0].range_delta_two, bank_r[0].range_delta_one}))
      else $error("Delta word shows the wrong channel bank.");

   AST_ODD_PARITY: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && rd_en && trim_addr(rd_addr) &&
      rd_addr != buck_trim_pkg::OFS_UNUSED_TEMP_COEFF |=> ^rd_data_r[8:0] == 1'b1)
      else $error("Trimming word parity is not odd.");

   AST_RANGE_FIVE: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_RANGE_FIVE_HOT_TRIM) |=>
      rd_data_r[7] == 1'b0 && rd_data_r[6:0] == $past(bank_view.range_five_hot_constant))
      else $error("Range-5 constant field is wrong.");

   AST_DELTA_FOUR_THREE: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_RANGE_DELTA_FOUR_THREE) |=>
      rd_data_r[9] == 1'b0 && rd_data_r[7:4] == $past(bank_view.range_delta_four) &&
      rd_data_r[3:0] == $past(bank_view.range_delta_three))
      else $error("Delta four/three word is misplaced.");

   AST_COEFF_CH1: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_TEMP_COEFF_CHANNEL_ONE) |=> rd_valid_r &&
      rd_data_r[7:0] == {coeff_r.ch1_high_range_coeff, coeff_r.ch1_low_range_coeff})
      else $error("Channel one coefficient word is wrong.");

   AST_COEFF_CH2: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_TEMP_COEFF_CHANNEL_TWO) |=> rd_valid_r &&
      rd_data_r[7:0] == {coeff_r.ch2_high_range_coeff, coeff_r.ch2_low_range_coeff})
      else $error("Channel two coefficient word is wrong.");

   AST_SPARE_ZERO: assert property (@(posedge core_clk) disable iff (reset)
      seq_rd(buck_trim_pkg::OFS_UNUSED_TEMP_COEFF) |=> rd_data_r == 10'h000 && addr_hit_r)
      else $error("Unused coefficient word is not all zero.");

   AST_READ_ONLY: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && wr_en && trim_addr(wr_addr) |=> wr_refused_r && $stable(coeff_r) &&
      $stable(bank_r[0]) && $stable(bank_r[1]))
      else $error("Write altered a trimming word or was not refused.");

   AST_BANK_CHANGE: assert property (@(posedge core_clk) disable iff (reset)
      seq_bank_flip ##0 seq_rd(buck_trim_pkg::OFS_RANGE_FIVE_HOT_TRIM) |=>
      rd_data_r[6:0] == ($past(bank_select) ? bank_r[1].range_five_hot_constant :
                                              bank_r[0].range_five_hot_constant))
      else $error("Read after bank change returned the old bank.");

endmodule

// ===== design/buck_trim_pkg.sv
// Constants and carrier types for the buck current-sense trimming word bank.
package buck_trim_pkg;

   localparam int WORD_W = 10;
   localparam int ADDR_W = 5;
   localparam int CONST_W = 7;
   localparam int FIELD_W = 4;

   // Word offsets on the serial register map.
   localparam logic [4:0] OFS_RANGE_FIVE_HOT_TRIM = 5'h18;
   localparam logic [4:0] OFS_RANGE_DELTA_TWO_ONE = 5'h19;
   localparam logic [4:0] OFS_RANGE_DELTA_FOUR_THREE = 5'h1a;
   localparam logic [4:0] OFS_TEMP_COEFF_CHANNEL_ONE = 5'h1b;
   localparam logic [4:0] OFS_TEMP_COEFF_CHANNEL_TWO = 5'h1c;
   localparam logic [4:0] OFS_UNUSED_TEMP_COEFF = 5'h1d;

   // Field positions inside a word.
   localparam int POS_PARITY = 8;
   localparam int POS_HIGH_FIELD = 4;
   localparam int POS_LOW_FIELD = 0;

   // Reset values.
   localparam logic [9:0] UNUSED_TEMP_COEFF_RESET = 10'h000;
   localparam logic [9:0] READ_DATA_RESET = 10'h000;
   localparam logic [3:0] SPARE_COEFF_RESET = 4'h0;

   // Per-channel trim set, selected by the bank-select bit.
   typedef struct packed {
      logic [6:0] range_five_hot_constant;
      logic [3:0] range_delta_four;
      logic [3:0] range_delta_three;
      logic [3:0] range_delta_two;
      logic [3:0] range_delta_one;
   } trim_bank_type;

   // Temperature coefficients, not banked.
   typedef struct packed {
      logic [3:0] ch2_high_range_coeff;
      logic [3:0] ch2_low_range_coeff;
      logic [3:0] ch1_high_range_coeff;
      logic [3:0] ch1_low_range_coeff;
   } coeff_set_type;

endpackage

// ===== test/buck_current_trim_registers_tb_top.sv
// Self-checking bench for the buck trimming word bank.
`timescale 1ns/1ps
module buck_current_trim_registers_tb_top;
   logic core_clk, reset, clk_en, bank_select, rd_en, wr_en, rd_valid_r, addr_hit_r;
   logic wr_refused_r, v;
   logic [4:0] rd_addr, wr_addr;
   logic [9:0] rd_data_r, got;
   buck_trim_pkg::trim_bank_type trim_ch1, trim_ch2;
   buck_trim_pkg::coeff_set_type coeff_in;
   int mismatches = 0;
   int samples_checked = 0;
   int unsigned seed = 95;
   int tv[3][5];
   int pat[4] = '{8'h00, 8'hff, 8'h08, 8'h77};
   buck_current_trim_registers i_buck_current_trim_registers (.core_clk(core_clk),
      .reset(reset), .clk_en(clk_en), .bank_select(bank_select), .rd_en(rd_en),
      .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .trim_ch1(trim_ch1),
      .trim_ch2(trim_ch2), .coeff_in(coeff_in), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r), .addr_hit_r(addr_hit_r), .wr_refused_r(wr_refused_r));
   trim_reader i_trim_reader (.core_clk(core_clk), .rd_valid_r(rd_valid_r),
      .rd_data_r(rd_data_r), .rd_en(rd_en), .rd_addr(rd_addr));
   function automatic int unsigned xr();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] exp_word(int a, int b);
      int lo;
      lo = 0;
      case (a)
         5'h18: lo = tv[b][0];
         5'h19: lo = tv[b][2] * 16 + tv[b][1];
         5'h1a: lo = tv[b][4] * 16 + tv[b][3];
         5'h1b: lo = tv[2][1] * 16 + tv[2][0];
         5'h1c: lo = tv[2][3] * 16 + tv[2][2];
         default: return 10'h000;
      endcase
      return {1'b0, ~^lo[7:0], lo[7:0]};
   endfunction
   function automatic logic [9:0] hit(int a);
      return {9'h000, a >= 5'h18 && a <= 5'h1d};
   endfunction
   task automatic check(input logic [9:0] g, input logic [9:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Pattern 0 is random; the others put every field at a code-table boundary.
   task automatic load(input int m);
      for (int b = 0; b < 3; b++) begin
         for (int f = 0; f < 5; f++) begin
            tv[b][f] = (m == 0 ? xr() : pat[m]) & (f == 0 && b < 2 ? 8'h7f : 8'h0f);
         end
      end
      @(posedge core_clk);
      reset <= 1'b1;
      trim_ch1 <= {7'(tv[0][0]), 4'(tv[0][4]), 4'(tv[0][3]), 4'(tv[0][2]), 4'(tv[0][1])};
      trim_ch2 <= {7'(tv[1][0]), 4'(tv[1][4]), 4'(tv[1][3]), 4'(tv[1][2]), 4'(tv[1][1])};
      coeff_in <= {4'(tv[2][3]), 4'(tv[2][2]), 4'(tv[2][1]), 4'(tv[2][0])};
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      trim_ch1 <= ~trim_ch1;
      trim_ch2 <= ~trim_ch2;
      coeff_in <= ~coeff_in;
      #1;
      check(rd_data_r, 10'h000);
   endtask
   task automatic read_all(input int b);
      @(posedge core_clk);
      bank_select <= b[0];
      for (int a = 5'h16; a < 6'h20; a++) begin
         i_trim_reader.read_word(5'(a), got, v);
         check({9'h000, v}, 10'h001);
         check(got, exp_word(a, b));
         check({9'h000, addr_hit_r}, hit(a));
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      {reset, clk_en, bank_select, wr_en, wr_addr} = 9'h180;
      {trim_ch1, trim_ch2, coeff_in} = '0;
      for (int m = 0; m < 4; m++) begin
         load(m);
         read_all(0);
         for (int a = 5'h17; a < 5'h1f; a++) begin
            @(posedge core_clk);
            wr_en <= 1'b1;
            wr_addr <= 5'(a);
            @(posedge core_clk);
            wr_en <= 1'b0;
            #1;
            check({9'h000, wr_refused_r}, hit(a));
         end
         read_all(1);
         read_all(0);
         @(posedge core_clk);
         clk_en <= 1'b0;
         i_trim_reader.read_word(5'h19, got, v);
         @(posedge core_clk);
         clk_en <= 1'b1;
         check({9'h000, v}, 10'h000);
         $display("test %0d done", m);
      end
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      give_verdict();
   end
endmodule

// ===== test/trim_reader.sv
// Host model that fetches single trimming words from the bank.
`timescale 1ns/1ps
module trim_reader (
   input wire logic core_clk,
   input wire logic rd_valid_r,
   input wire logic [9:0] rd_data_r,
   output logic rd_en,
   output logic [4:0] rd_addr
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 5'h00;
   end
   // The offset is inverted once released so a stale address never looks valid.
   task automatic read_word(input logic [4:0] a, output logic [9:0] w, output logic v);
      @(posedge core_clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      #1;
      v = rd_valid_r;
      w = rd_data_r;
   endtask
endmodule
